/* verilog/pcsd_pkg.sv */
// constants for the peripheral clock select and divide block
package pcsd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_PERI   = 12'h088;
  localparam logic [11:0] OFS_SDCARD = 12'h08C;
  localparam logic [11:0] OFS_EMSD   = 12'h090;
  localparam logic [11:0] OFS_SER0   = 12'h094;
  localparam logic [11:0] OFS_SER1   = 12'h098;
  localparam logic [11:0] OFS_SER2   = 12'h09C;
  localparam logic [11:0] OFS_SER3   = 12'h0A0;
  localparam logic [11:0] OFS_FR0    = 12'h0A4;
  localparam logic [11:0] OFS_FR1    = 12'h0A8;
  localparam logic [11:0] OFS_FR2    = 12'h0AC;
  localparam logic [11:0] OFS_FR3    = 12'h0B0;
  localparam logic [11:0] OFS_ETH    = 12'h0B4;
  localparam logic [11:0] OFS_FADC   = 12'h0B8;
  localparam logic [11:0] OFS_WIFI   = 12'h0BC;
  localparam logic [11:0] OFS_SADC   = 12'h0C0;
  localparam logic [11:0] OFS_SPI    = 12'h0C4;
  localparam int          NREG       = 16;

  // register indices, offset minus the first one, in words
  localparam logic [3:0] R_PERI = 4'h0;
  localparam logic [3:0] R_SD   = 4'h1;
  localparam logic [3:0] R_EMSD = 4'h2;
  localparam logic [3:0] R_SER0 = 4'h3;
  localparam logic [3:0] R_SER3 = 4'h6;
  localparam logic [3:0] R_FR0  = 4'h7;
  localparam logic [3:0] R_FR3  = 4'hA;
  localparam logic [3:0] R_ETH  = 4'hB;
  localparam logic [3:0] R_FADC = 4'hC;
  localparam logic [3:0] R_WIFI = 4'hD;
  localparam logic [3:0] R_SADC = 4'hE;
  localparam logic [3:0] R_SPI  = 4'hF;

  // ----------------------------------------------------------------
  // reset values and writable bits of the masked registers
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PERI = 16'hA101;
  localparam logic [15:0] RST_SD   = 16'h2780;
  localparam logic [15:0] RST_EMSD = 16'h8080;
  localparam logic [15:0] RST_SER  = 16'h0200;
  localparam logic [15:0] RST_ETH  = 16'h0B00;
  localparam logic [15:0] RST_FADC = 16'h0900;
  localparam logic [15:0] RST_SADC = 16'h1700;
  localparam logic [15:0] RST_SPI  = 16'h0707;
  localparam logic [31:0] RST_FRAC = 32'h0BB8EA60;
  localparam logic [15:0] WM_PERI  = 16'hB31F;
  localparam logic [15:0] WM_SD    = 16'h3FFF;
  localparam logic [15:0] WM_EMSD  = 16'hFFFF;
  localparam logic [15:0] WM_SER0  = 16'hFB7F;
  localparam logic [15:0] WM_SER   = 16'h037F;
  localparam logic [15:0] WM_ETH   = 16'h1F13;
  localparam logic [15:0] WM_FADC  = 16'hFF93;
  localparam logic [15:0] WM_SADC  = 16'hFF00;
  localparam logic [15:0] WM_SPI   = 16'hFFFF;

  // ----------------------------------------------------------------
  // field positions (low bit of each field)
  // ----------------------------------------------------------------
  localparam int F_PERI_SRC  = 15;
  localparam int F_PERI_PCLK = 12;
  localparam int F_PERI_HCLK = 8;
  localparam int F_HI_SEL    = 14;
  localparam int F_HI_DIV    = 8;
  localparam int F_LO_SEL    = 6;
  localparam int F_SER_PLL   = 15;
  localparam int F_SER0_SRC  = 13;
  localparam int F_PHY_SEL   = 11;
  localparam int F_SER_OUT   = 8;
  localparam int F_ETH_RMII  = 4;
  localparam int F_FADC_INV  = 7;
  localparam int F_FADC_EXT  = 4;
  localparam int F_WIFI_PLL  = 1;
  localparam int F_FADC_PLL  = 0;
  localparam int F_NUM       = 16;

  // ----------------------------------------------------------------
  // source tick indices and divider indices
  // ----------------------------------------------------------------
  localparam int S_CODEC = 0;
  localparam int S_GEN   = 1;
  localparam int S_NEW   = 2;
  localparam int S_OSC   = 3;
  localparam int S_HOST0 = 4;
  localparam int S_HOST1 = 5;
  localparam int S_OTG   = 6;
  localparam int S_RMII  = 7;
  localparam int S_ADCX  = 8;
  localparam int NSRC    = 9;
  localparam int D_ACLK  = 0;
  localparam int D_PCLK  = 1;
  localparam int D_HCLK  = 2;
  localparam int D_SD    = 3;
  localparam int D_EMMC  = 4;
  localparam int D_SDIO  = 5;
  localparam int D_SER   = 6;
  localparam int D_ETH   = 10;
  localparam int D_FADC  = 11;
  localparam int D_SADC  = 12;
  localparam int NDIV    = 13;
  localparam int NSER    = 4;
  localparam int FR_WIFI = 4;
  localparam int NFRAC   = 5;
  localparam int DW      = 8;

  // serial output select codes
  localparam logic [1:0] OUT_INT  = 2'h0;
  localparam logic [1:0] OUT_FRAC = 2'h1;
  localparam logic [1:0] OUT_OSC  = 2'h2;

  // ----------------------------------------------------------------
  // decoding helpers used by the top level
  // ----------------------------------------------------------------
  // codec / general / 24MHz selector shared by the storage clocks
  function automatic logic pick_cgo(input logic [NSRC-1:0] t,
                                    input logic [1:0] code);
    case (code)
      2'h0:    pick_cgo = t[S_CODEC];
      2'h1:    pick_cgo = t[S_GEN];
      2'h2:    pick_cgo = t[S_OSC];
      default: pick_cgo = 1'b0;
    endcase
  endfunction

  // ratio code to divide value; code 3 on hclk is undefined, held at 4:1
  function automatic logic [DW-1:0] ratio_div(input logic [1:0] code,
                                              input logic allow8);
    case (code)
      2'h0:    ratio_div = 8'h00;
      2'h1:    ratio_div = 8'h01;
      2'h2:    ratio_div = 8'h03;
      default: ratio_div = allow8 ? 8'h07 : 8'h03;
    endcase
  endfunction

  function automatic logic [15:0] reg_wmask(input logic [3:0] idx);
    case (idx)
      R_PERI:  reg_wmask = WM_PERI;
      R_SD:    reg_wmask = WM_SD;
      R_EMSD:  reg_wmask = WM_EMSD;
      R_SER0:  reg_wmask = WM_SER0;
      R_ETH:   reg_wmask = WM_ETH;
      R_FADC:  reg_wmask = WM_FADC;
      R_SADC:  reg_wmask = WM_SADC;
      R_SPI:   reg_wmask = WM_SPI;
      default: reg_wmask = WM_SER;
    endcase
  endfunction

  function automatic logic [31:0] reg_reset(input logic [3:0] idx);
    case (idx)
      R_PERI:  reg_reset = {16'h0000, RST_PERI};
      R_SD:    reg_reset = {16'h0000, RST_SD};
      R_EMSD:  reg_reset = {16'h0000, RST_EMSD};
      R_ETH:   reg_reset = {16'h0000, RST_ETH};
      R_FADC:  reg_reset = {16'h0000, RST_FADC};
      R_SADC:  reg_reset = {16'h0000, RST_SADC};
      R_SPI:   reg_reset = {16'h0000, RST_SPI};
      default: reg_reset = {16'h0000, RST_SER};
    endcase
  endfunction

  function automatic logic is_frac(input logic [3:0] idx);
    is_frac = ((idx >= R_FR0) && (idx <= R_FR3)) || (idx == R_WIFI);
  endfunction

endpackage

/* verilog/pcsd_int_div.sv */
// integer clock divider working on source ticks
`timescale 1ns/1ps
module pcsd_int_div
  import pcsd_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         src_tick,
  input  wire logic [W-1:0] div_value,
  output logic              out_tick
);

  logic [W-1:0] count;
  logic [W-1:0] cur_div;
  logic [W-1:0] next_count;
  logic [W-1:0] next_cur_div;
  logic         next_out_tick;

  // ----------------------------------------------------------------
  // count source ticks, reload only at the end of a period
  // ----------------------------------------------------------------
  // the new value is sampled at terminal count so a change never
  // cuts a period short; the period in progress finishes first
  always_comb begin
    next_count    = count;
    next_cur_div  = cur_div;
    next_out_tick = 1'b0;
    if (src_tick) begin
      if (count >= cur_div) begin
        next_count    = '0;
        next_cur_div  = div_value;
        next_out_tick = 1'b1;
      end else begin
        next_count = count + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count    <= '0;
      cur_div  <= '0;
      out_tick <= 1'b0;
    end else begin
      count    <= next_count;
      cur_div  <= next_cur_div;
      out_tick <= next_out_tick;
    end
  end

endmodule

/* verilog/pcsd_top.sv */
// peripheral clock source selection and division with apb registers
// ------------------------------------------------------------------
// Overview of operation
// - masked writes change a low bit only where its upper mask bit is set
// - pclk ratio code 0..3 gives aclk to pclk 1:1, 2:1, 4:1, 8:1
// - hclk ratio code 0..2 gives aclk to hclk 1:1, 2:1, 4:1
// - peripheral aclk is selected source over five-bit divide plus one
// - sd card source codec, general, 24MHz, reset 24MHz; divide plus one
// - emmc and sdio0 sources are codec, general or 24MHz
// - emmc and sdio0 clocks are source over six-bit divide plus one
// - one bit picks codec or general pll for serial ports one to three
// - serial0 source is codec, general, phy fast clock or new pll
// - phy fast clock comes from host0, host1 or otg pll
// - serial output picks integer, fractional or 24MHz; resets to 24MHz
// - serial integer clock is source over seven-bit divide plus one
// - serial fractional clock is source times numerator over denominator
// - ethernet reference is source over five-bit divide plus one, reset 11
// - rmii clock picks internal divider or external input
// - ethernet source order is new, codec, general pll
// - fast adc clock toggles at source over eight-bit divide plus one, reset 9
// - fast adc output is buffered or inverted
// - fast adc clock picks internal divider or external input
// - wireless and fast adc sources pick codec or general pll
// - wireless fractional factor is numerator high, denominator low
// - slow adc clock is 24MHz over eight-bit divide plus one, reset 23
// ------------------------------------------------------------------
`timescale 1ns/1ps
module pcsd_top
  import pcsd_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             codec_pll_clk,
  input  wire logic             general_pll_clk,
  input  wire logic             new_pll_clk,
  input  wire logic             osc24_clk,
  input  wire logic             host0_phy_clk,
  input  wire logic             host1_phy_clk,
  input  wire logic             otg_phy_clk,
  input  wire logic             rmii_ext_clk,
  input  wire logic             fast_adc_ext_clk,
  output logic                  periph_aclk_tick,
  output logic                  periph_hclk_tick,
  output logic                  periph_pclk_tick,
  output logic                  sdcard_tick,
  output logic                  emmc_tick,
  output logic                  sdio_tick,
  output logic      [NSER-1:0]  serial_tick,
  output logic                  phy_fast_tick,
  output logic                  ethernet_ref_tick,
  output logic                  fast_adc_clk,
  output logic                  wireless_tick,
  output logic                  slow_adc_tick
);

  // ----------------------------------------------------------------
  // reset release and source synchronisers
  // ----------------------------------------------------------------
  logic            rst_meta;
  logic            rst_n;
  logic [NSRC-1:0] src_raw;
  logic [NSRC-1:0] src_meta;
  logic [NSRC-1:0] src_sync;
  logic [NSRC-1:0] src_last;
  logic [NSRC-1:0] tick;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // source clocks are sampled as levels, so each must stay below half
  // the system rate; a rising edge of the sampled copy is one tick
  assign src_raw = {fast_adc_ext_clk, rmii_ext_clk, otg_phy_clk,
                    host1_phy_clk, host0_phy_clk, osc24_clk,
                    new_pll_clk, general_pll_clk, codec_pll_clk};
  assign tick    = src_sync & ~src_last;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_meta <= '0;
      src_sync <= '0;
      src_last <= '0;
    end else begin
      src_meta <= src_raw;
      src_sync <= src_meta;
      src_last <= src_sync;
    end
  end

  // ----------------------------------------------------------------
  // apb slave and register file
  // ----------------------------------------------------------------
  logic [31:0] regs [NREG];
  logic [31:0] next_regs [NREG];
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [3:0]  idx;
  logic        hit;
  logic        done;
  logic [15:0] wm;

  assign idx  = 4'((paddr - OFS_PERI) >> 2);
  assign hit  = (paddr >= OFS_PERI) && (paddr <= (OFS_SPI + 12'h003));
  assign done = psel && penable && pready;
  assign wm   = reg_wmask(idx);

  // one wait state: pready rises in the second access cycle
  always_comb begin
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !hit;
    next_prdata  = 32'h00000000;
    if (next_pready && hit && !pwrite) begin
      next_prdata = is_frac(idx) ? regs[idx] : {16'h0000, regs[idx][15:0] & wm};
    end
    for (int i = 0; i < NREG; i++) begin
      next_regs[i] = regs[i];
    end
    if (done && pwrite && hit) begin
      if (is_frac(idx)) begin
        next_regs[idx] = pwdata;
      end else begin
        next_regs[idx][15:0] = (regs[idx][15:0] & ~(pwdata[31:16] & wm)) |
                               (pwdata[15:0] & pwdata[31:16] & wm);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= is_frac(4'(i)) ? RST_FRAC : reg_reset(4'(i));
      end
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // source selection for the integer dividers
  // ----------------------------------------------------------------
  logic [NDIV-1:0] div_src;
  logic [DW-1:0]   div_val [NDIV];
  logic [NDIV-1:0] div_out;
  logic [NSER-1:0] ser_src;
  logic            phy_src;
  logic            eth_src;
  logic            wifi_src;

  always_comb begin
    // phy fast clock and serial sources
    case (regs[R_SER0][F_PHY_SEL +: 2])
      2'h0:    phy_src = tick[S_HOST0];
      2'h1:    phy_src = tick[S_HOST1];
      2'h2:    phy_src = tick[S_OTG];
      default: phy_src = 1'b0;
    endcase
    case (regs[R_SER0][F_SER0_SRC +: 2])
      2'h0:    ser_src[0] = tick[S_CODEC];
      2'h1:    ser_src[0] = tick[S_GEN];
      2'h2:    ser_src[0] = phy_src;
      default: ser_src[0] = tick[S_NEW];
    endcase
    for (int s = 1; s < NSER; s++) begin
      ser_src[s] = regs[R_SER0][F_SER_PLL] ? tick[S_GEN] : tick[S_CODEC];
    end
    // ethernet uses its own order, code 3 stops the clock
    case (regs[R_ETH][1:0])
      2'h0:    eth_src = tick[S_NEW];
      2'h1:    eth_src = tick[S_CODEC];
      2'h2:    eth_src = tick[S_GEN];
      default: eth_src = 1'b0;
    endcase
    wifi_src = regs[R_FADC][F_WIFI_PLL] ? tick[S_GEN] : tick[S_CODEC];

    div_src[D_ACLK] = regs[R_PERI][F_PERI_SRC] ? tick[S_GEN] : tick[S_CODEC];
    div_val[D_ACLK] = DW'(regs[R_PERI][4:0]);
    div_src[D_PCLK] = div_out[D_ACLK];
    div_val[D_PCLK] = ratio_div(regs[R_PERI][F_PERI_PCLK +: 2], 1'b1);
    div_src[D_HCLK] = div_out[D_ACLK];
    div_val[D_HCLK] = ratio_div(regs[R_PERI][F_PERI_HCLK +: 2], 1'b0);
    div_src[D_SD]   = pick_cgo(tick, regs[R_SD][F_LO_SEL +: 2]);
    div_val[D_SD]   = DW'(regs[R_SD][5:0]);
    div_src[D_EMMC] = pick_cgo(tick, regs[R_EMSD][F_HI_SEL +: 2]);
    div_val[D_EMMC] = DW'(regs[R_EMSD][F_HI_DIV +: 6]);
    div_src[D_SDIO] = pick_cgo(tick, regs[R_EMSD][F_LO_SEL +: 2]);
    div_val[D_SDIO] = DW'(regs[R_EMSD][5:0]);
    for (int s = 0; s < NSER; s++) begin
      div_src[D_SER + s] = ser_src[s];
      div_val[D_SER + s] = DW'(regs[R_SER0 + 4'(s)][6:0]);
    end
    div_src[D_ETH]  = eth_src;
    div_val[D_ETH]  = DW'(regs[R_ETH][F_HI_DIV +: 5]);
    div_src[D_FADC] = regs[R_FADC][F_FADC_PLL] ? tick[S_GEN] : tick[S_CODEC];
    div_val[D_FADC] = regs[R_FADC][F_HI_DIV +: 8];
    div_src[D_SADC] = tick[S_OSC];
    div_val[D_SADC] = regs[R_SADC][F_HI_DIV +: 8];
  end

  // one divider structure serves every integer ratio in the block
  for (genvar g = 0; g < NDIV; g++) begin : g_div
    pcsd_int_div #(.W(DW)) u_div (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .src_tick  (div_src[g]),
      .div_value (div_val[g]),
      .out_tick  (div_out[g])
    );
  end

  // ----------------------------------------------------------------
  // fractional dividers (serial ports and wireless)
  // ----------------------------------------------------------------
  logic [15:0]      acc [NFRAC];
  logic [15:0]      next_acc [NFRAC];
  logic [NFRAC-1:0] frac_out;
  logic [NFRAC-1:0] next_frac_out;
  logic [NFRAC-1:0] frac_src;

  // accumulate numerator per source tick; pulse on each overflow past
  // the denominator; a zero denominator stops the output, and a ratio
  // above one is clamped to one pulse per source tick
  always_comb begin
    logic [16:0] sum;
    logic [15:0] num;
    logic [15:0] den;
    sum = 17'h00000;
    num = 16'h0000;
    den = 16'h0000;
    for (int f = 0; f < NFRAC; f++) begin
      next_acc[f]      = acc[f];
      next_frac_out[f] = 1'b0;
      if (f == FR_WIFI) begin
        frac_src[f] = wifi_src;
        num = regs[R_WIFI][F_NUM +: 16];
        den = regs[R_WIFI][15:0];
      end else begin
        frac_src[f] = ser_src[f];
        num = regs[R_FR0 + 4'(f)][F_NUM +: 16];
        den = regs[R_FR0 + 4'(f)][15:0];
      end
      sum = {1'b0, acc[f]} + {1'b0, num};
      if (frac_src[f] && (den != 16'h0000)) begin
        if (sum >= {1'b0, den}) begin
          next_frac_out[f] = 1'b1;
          next_acc[f] = (sum - {1'b0, den} >= {1'b0, den}) ? 16'h0000
                        : 16'(sum - {1'b0, den});
        end else begin
          next_acc[f] = sum[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frac_out <= '0;
      for (int f = 0; f < NFRAC; f++) begin
        acc[f] <= 16'h0000;
      end
    end else begin
      frac_out <= next_frac_out;
      for (int f = 0; f < NFRAC; f++) begin
        acc[f] <= next_acc[f];
      end
    end
  end

  // ----------------------------------------------------------------
  // output selection, all outputs registered
  // ----------------------------------------------------------------
  logic [NSER-1:0] next_serial;
  logic            next_eth;
  logic            next_fadc;
  logic            fadc_phase;
  logic            next_fadc_phase;
  logic            fadc_tick;

  always_comb begin
    for (int s = 0; s < NSER; s++) begin
      case (regs[R_SER0 + 4'(s)][F_SER_OUT +: 2])
        OUT_INT:  next_serial[s] = div_out[D_SER + s];
        OUT_FRAC: next_serial[s] = frac_out[s];
        OUT_OSC:  next_serial[s] = tick[S_OSC];
        default:  next_serial[s] = 1'b0;
      endcase
    end
    next_eth = regs[R_ETH][F_ETH_RMII] ? tick[S_RMII] : div_out[D_ETH];
    fadc_tick = regs[R_FADC][F_FADC_EXT] ? tick[S_ADCX] : div_out[D_FADC];
    // the adc clock is a level: it toggles per tick, then may invert
    next_fadc_phase = fadc_phase ^ fadc_tick;
    next_fadc = next_fadc_phase ^ regs[R_FADC][F_FADC_INV];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      periph_aclk_tick  <= 1'b0;
      periph_hclk_tick  <= 1'b0;
      periph_pclk_tick  <= 1'b0;
      sdcard_tick       <= 1'b0;
      emmc_tick         <= 1'b0;
      sdio_tick         <= 1'b0;
      serial_tick       <= '0;
      phy_fast_tick     <= 1'b0;
      ethernet_ref_tick <= 1'b0;
      fadc_phase        <= 1'b0;
      fast_adc_clk      <= 1'b0;
      wireless_tick     <= 1'b0;
      slow_adc_tick     <= 1'b0;
    end else begin
      periph_aclk_tick  <= div_out[D_ACLK];
      periph_hclk_tick  <= div_out[D_HCLK];
      periph_pclk_tick  <= div_out[D_PCLK];
      sdcard_tick       <= div_out[D_SD];
      emmc_tick         <= div_out[D_EMMC];
      sdio_tick         <= div_out[D_SDIO];
      serial_tick       <= next_serial;
      phy_fast_tick     <= phy_src;
      ethernet_ref_tick <= next_eth;
      fadc_phase        <= next_fadc_phase;
      fast_adc_clk      <= next_fadc;
      wireless_tick     <= frac_out[FR_WIFI];
      slow_adc_tick     <= div_out[D_SADC];
    end
  end

endmodule

/* tb/pcsd_monitor.sv */
// port checker for the peripheral clock select and divide block
`timescale 1ns/1ps
module pcsd_monitor
  import pcsd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        sdcard_tick,
  input  wire logic        ethernet_ref_tick
);
  // ----------------------------------------------------------------
  // bus handshake and clock pulse checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_ready_wait_state: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("no single wait state");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_err_address: assert property (pready |-> pslverr == (paddr < OFS_PERI || paddr > 12'h0C7))
    else $error("error flag does not match address");
  a_read_upper_zero: assert property (pready && !pwrite && !paddr[5] |-> prdata[31:16] == 16'h0)
    else $error("mask half reads nonzero");
  a_sd_pulse_short: assert property (sdcard_tick |=> !sdcard_tick) else $error("long sd pulse");
  a_eth_pulse_gap: assert property (ethernet_ref_tick |=> !ethernet_ref_tick [*3])
    else $error("ethernet pulses too close");
endmodule

bind pcsd_top pcsd_monitor mon_u (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .sdcard_tick, .ethernet_ref_tick);

/* tb/testbench.sv */
// self-checking bench for the peripheral clock select and divide block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import pcsd_pkg::*;
  logic            clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0]     paddr = 0, a;
  logic [31:0]     pwdata = 0, prdata, rd, wd, old;
  logic            pready, pslverr, fast_adc_clk;
  logic            periph_aclk_tick, periph_hclk_tick, periph_pclk_tick, sdcard_tick;
  logic            emmc_tick, sdio_tick, phy_fast_tick, ethernet_ref_tick;
  logic            wireless_tick, slow_adc_tick;
  logic [NSER-1:0] serial_tick;
  logic [NSRC-1:0] src = '0;
  logic [5:0]      tk;
  int              cyc = 0, err_count = 0, compares = 0, d, e, g;
  int              per[NSRC] = '{10, 12, 14, 8, 16, 18, 20, 22, 24};
  int              sm[5][4] = '{'{S_CODEC, S_GEN, S_OSC, 0}, '{S_CODEC, S_GEN, S_HOST0, S_NEW},
                                '{S_NEW, S_CODEC, S_GEN, 0}, '{S_OSC, 0, 0, 0},
                                '{S_CODEC, 0, 0, 0}};
  logic [11:0]     ra[7] = '{OFS_PERI, OFS_SDCARD, OFS_SER0, OFS_FR1, OFS_ETH, OFS_FADC, OFS_SADC};
  logic [31:0]     rv[7] = '{{16'h0, RST_PERI}, {16'h0, RST_SD}, {16'h0, RST_SER}, RST_FRAC,
                            {16'h0, RST_ETH}, {16'h0, RST_FADC}, {16'h0, RST_SADC}};
  assign tk = {periph_pclk_tick, wireless_tick, slow_adc_tick, ethernet_ref_tick, serial_tick[0],
               sdcard_tick};

  pcsd_top dut_u (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .codec_pll_clk(src[S_CODEC]), .general_pll_clk(src[S_GEN]),
    .new_pll_clk(src[S_NEW]), .osc24_clk(src[S_OSC]), .host0_phy_clk(src[S_HOST0]),
    .host1_phy_clk(src[S_HOST1]), .otg_phy_clk(src[S_OTG]), .rmii_ext_clk(src[S_RMII]),
    .fast_adc_ext_clk(src[S_ADCX]), .periph_aclk_tick, .periph_hclk_tick, .periph_pclk_tick,
    .sdcard_tick, .emmc_tick, .sdio_tick, .serial_tick, .phy_fast_tick, .ethernet_ref_tick,
    .fast_adc_clk, .wireless_tick, .slow_adc_tick);

  // ----------------------------------------------------------------
  // clock and source clocks, each a whole number of system cycles
  // ----------------------------------------------------------------
  initial forever #12.5 clk_sys = ~clk_sys;
  // sources derived from one counter so every period is exact in cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    for (int i = 0; i < NSRC; i++) src[i] <= (cyc % per[i]) < per[i] / 2;
  end

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] dw,
                     output logic [31:0] r, output logic ee);
    @(posedge clk_sys);
    psel <= 1; pwrite <= w; paddr <= ad; pwdata <= dw;
    @(posedge clk_sys);
    penable <= 1;
    // no cycle budget here: only the hang guard may end this wait
    do begin @(posedge clk_sys); end while (pready !== 1'b1);
    r = prdata; ee = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // cycles between the second and third pulse seen after the call
  task automatic gap(input int i, output int gg);
    int n, t;
    n = 0; t = 0; gg = 0;
    while (n < 3 && t < 5000) begin
      @(posedge clk_sys);
      t++;
      if (tk[i] === 1'b1) begin n++; gg = t; t = 0; end
    end
  endtask

  // expected pulse spacing: divide plus one source periods; pclk also scaled by its ratio code
  function automatic int exp_gap(input int k, input int c, input int d);
    return (k == 5) ? ((d + 1) * per[S_CODEC]) << c : (d + 1) * per[sm[k][c]];
  endfunction

  task automatic close_out;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far beyond the expected run of a few thousand cycles
  initial begin
    #2_000_000;
    err_count++;
    close_out();
  end

  initial begin
    void'($urandom(44));
    repeat (3) @(posedge clk_sys);
    rstn <= 1;
    repeat (4) @(posedge clk_sys);
    foreach (ra[i]) begin apb(0, ra[i], 0, rd, er); `CHK(rd, rv[i]) end
    for (int i = 0; i < 4; i++) begin
      wd = $urandom;
      apb(0, OFS_EMSD, 0, old, er);
      apb(1, OFS_EMSD, wd, rd, er);
      apb(0, OFS_EMSD, 0, rd, er);
      `CHK(rd[15:0], (old[15:0] & ~wd[31:16] | wd[15:0] & wd[31:16]) & WM_EMSD)
    end
    apb(1, 12'h200, 32'hFFFFFFFF, rd, er);
    `CHK({er, rd}, 33'h100000000)
    // every source code of the sd, serial0 and ethernet selects, every pclk ratio code, random divide, period measured in cycles
    for (int k = 0; k < 6; k++)
      for (int c = 0; c < ((k % 4 == 1) ? 4 : (k > 2) ? 1 : 3); c++) begin
        d = $urandom_range(7);
        case (k)
          0: begin a = OFS_SDCARD; wd = 32'h00FF0000 | (c << 6) | d; end
          1: begin a = OFS_SER0; wd = 32'h637F0000 | (c << 13) | d; end
          2: begin a = OFS_ETH; wd = 32'h1F030000 | (d << 8) | c; end
          3: begin a = OFS_SADC; wd = 32'hFF000000 | (d << 8); end
          4: begin a = OFS_WIFI; wd = {16'h0001, 16'(d + 1)}; end
          default: begin a = OFS_PERI; wd = 32'hB01F0000 | (c << 12) | d; end
        endcase
        e = exp_gap(k, c, d);
        apb(1, a, wd, rd, er);
        gap(k, g);
        `CHK(g, e)
      end
    close_out();
  end
endmodule
